/* File: tpw_cfg.svh */
// Constants of the timer-based pulse width modulator: offsets, fields, resets.
// Assumes inclusion by bare name from the design files of this block.
`ifndef TPW_CFG_SVH
`define TPW_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define TPW_ADDR_MODE   8'hDA
`define TPW_ADDR_COUNT  8'hDB
`define TPW_ADDR_DUTY   8'hCD
`define TPW_ADDR_STAT   8'hC9

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define TPW_STAT_FLAG_BIT  0
`define TPW_STAT_IEN_BIT   1
`define TPW_MODE_RST       8'h00
`define TPW_COUNT_RST      8'h00
`define TPW_DUTY_RST       8'h00

// ****************************************************************
// Counting limits
// ****************************************************************
`define TPW_TOP_256   8'hFF
`define TPW_TOP_64    8'h3F
`define TPW_TOP_32    8'h1F
`define TPW_TOP_16    8'h0F
`define TPW_PRE_FULL  8'hFF

`endif

/* File: tpw_pkg.sv */
// Types shared by the pulse width modulator files.
// Assumes no other package; everything is referenced with its scope.
package tpw_pkg;

   // ****************************************************************
   // Mode register layout, bit 7 first
   // ****************************************************************
   typedef struct packed {
      logic       timer_on;
      logic [2:0] prescale_select;
      logic       clock_source_select;
      logic       reload_select;
      logic       toggle_output_select;
      logic       pulse_output_enable;
   } tpw_mode_s;

   // Pin drive pair
   typedef struct packed {
      logic o;
      logic oe;
   } tpw_pin_s;

   // Resolution codes {reload_select, toggle_output_select}
   typedef enum logic [1:0] {
      TPW_RES_256 = 2'b00,
      TPW_RES_64  = 2'b01,
      TPW_RES_32  = 2'b10,
      TPW_RES_16  = 2'b11
   } tpw_res_e;

endpackage : tpw_pkg

/* File: tpw_sync.sv */
// Three-stage input synchroniser with agreement filter and fall detect.
// Assumes the input is asynchronous to clk.
`timescale 1ns/10ps
module tpw_sync #(
   parameter logic IDLE = 1'b1
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic async_in,
   output logic      level,
   output logic      fall
);

   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic level_ff;

   // Shift chain, first stage read only by the second
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_ff <= IDLE;
         s2_ff <= IDLE;
         s3_ff <= IDLE;
      end else begin
         s1_ff <= async_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // Level moves once the two later stages agree
   always_ff @(posedge clk) begin
      if (rst) begin
         level_ff <= IDLE;
      end else if (s2_ff == s3_ff) begin
         level_ff <= s3_ff;
      end
   end

   assign level = level_ff;
   assign fall  = level_ff && (s2_ff == s3_ff) && !s3_ff;

endmodule : tpw_sync

/* File: tpw_timer.sv */
// Eight-bit up-counting timer with reload, double-buffered duty and PWM output.
// Assumes a plain register port with read data one cycle after the strobe,
// an asynchronous event pin and a GPIO driver sharing the output pin.
`timescale 1ns/10ps
`include "tpw_cfg.svh"
module tpw_timer (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [7:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic [7:0]            reg_rdata,
   input  wire logic             event_input_pin,
   input  wire tpw_pkg::tpw_pin_s gpio_drive,
   output tpw_pkg::tpw_pin_s      pulse_out_pin,
   output logic                  overflow_irq
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   tpw_pkg::tpw_mode_s mode_ff;
   tpw_pkg::tpw_mode_s nxt_mode;
   tpw_pkg::tpw_pin_s  pin_ff;
   logic [7:0] count_ff;
   logic [7:0] nxt_count;
   logic [7:0] duty_buf_ff;
   logic [7:0] duty_act_ff;
   logic [7:0] nxt_duty;
   logic [7:0] pre_ff;
   logic [7:0] pre_mask;
   logic [7:0] top;
   logic [7:0] nxt_top;
   logic [7:0] rdata_ff;
   logic       pwm_ff;
   logic       toggle_ff;
   logic       flag_ff;
   logic       nxt_flag;
   logic       ien_ff;
   logic       nxt_ien;
   logic       irq_ff;
   logic       wr_mode;
   logic       wr_count;
   logic       wr_duty;
   logic       wr_stat;
   logic       pre_tick;
   logic       ev_fall;
   logic       cnt_tick;
   logic       ovf;
   logic       start_pwm;

   // Overflow boundary for a mode
   function automatic logic [7:0] top_of(input tpw_pkg::tpw_mode_s m);
      tpw_pkg::tpw_res_e res;
      res = tpw_pkg::tpw_res_e'({m.reload_select, m.toggle_output_select});
      top_of = `TPW_TOP_256;
      if (m.pulse_output_enable && !m.clock_source_select) begin
         case (res)
            tpw_pkg::TPW_RES_256: top_of = `TPW_TOP_256;
            tpw_pkg::TPW_RES_64:  top_of = `TPW_TOP_64;
            tpw_pkg::TPW_RES_32:  top_of = `TPW_TOP_32;
            tpw_pkg::TPW_RES_16:  top_of = `TPW_TOP_16;
            default:              top_of = `TPW_TOP_256;
         endcase
      end
   endfunction : top_of

   // ****************************************************************
   // Register decode
   // ****************************************************************
   assign wr_mode  = reg_wr && (reg_addr == `TPW_ADDR_MODE);
   assign wr_count = reg_wr && (reg_addr == `TPW_ADDR_COUNT);
   assign wr_duty  = reg_wr && (reg_addr == `TPW_ADDR_DUTY);
   assign wr_stat  = reg_wr && (reg_addr == `TPW_ADDR_STAT);
   assign nxt_mode = wr_mode ? tpw_pkg::tpw_mode_s'(reg_wdata) : mode_ff;

   // Mode register
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_ff <= tpw_pkg::tpw_mode_s'(`TPW_MODE_RST);
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   // ****************************************************************
   // Count clock selection
   // ****************************************************************
   tpw_sync #(
      .IDLE     (1'b1)
   ) u_event_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in (event_input_pin),
      .level    (),
      .fall     (ev_fall)
   );

   // Free prescaler, held clear while the timer is off
   always_ff @(posedge clk) begin
      if (rst || !mode_ff.timer_on) begin
         pre_ff <= 8'h00;
      end else begin
         pre_ff <= pre_ff + 8'h01;
      end
   end

   assign pre_mask = `TPW_PRE_FULL >> mode_ff.prescale_select;
   assign pre_tick = (pre_ff & pre_mask) == pre_mask;
   assign cnt_tick = mode_ff.timer_on &&
                     (mode_ff.clock_source_select ? ev_fall : pre_tick);
   assign top      = top_of(mode_ff);
   assign nxt_top  = top_of(nxt_mode);
   assign ovf      = cnt_tick && ((count_ff & top) == top);
   assign start_pwm = nxt_mode.timer_on && !mode_ff.timer_on && nxt_mode.pulse_output_enable;

   // ****************************************************************
   // Counter and reload
   // ****************************************************************
   always_comb begin
      nxt_count = count_ff;
      if (wr_count) begin
         nxt_count = reg_wdata;
      end else if (start_pwm) begin
         nxt_count = 8'h00;
      end else if (ovf) begin
         if (mode_ff.pulse_output_enable) begin
            nxt_count = 8'h00;
         end else if (mode_ff.reload_select) begin
            nxt_count = duty_buf_ff;
         end else begin
            nxt_count = 8'h00;
         end
      end else if (cnt_tick) begin
         nxt_count = count_ff + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         count_ff <= `TPW_COUNT_RST;
      end else begin
         count_ff <= nxt_count;
      end
   end

   // Duty: buffer takes writes, active copy moves at overflow
   assign nxt_duty = (!mode_ff.timer_on || ovf) ? duty_buf_ff : duty_act_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         duty_buf_ff <= `TPW_DUTY_RST;
         duty_act_ff <= `TPW_DUTY_RST;
      end else begin
         duty_buf_ff <= wr_duty ? reg_wdata : duty_buf_ff;
         duty_act_ff <= nxt_duty;
      end
   end

   // ****************************************************************
   // Waveforms
   // ****************************************************************
   // High from period start until the count meets the duty
   always_ff @(posedge clk) begin
      if (rst) begin
         pwm_ff <= 1'b0;
      end else begin
         pwm_ff <= nxt_mode.timer_on &&
                   ((nxt_count & nxt_top) < (nxt_duty & nxt_top));
      end
   end

   // Half-duty toggle when modulation is off
   always_ff @(posedge clk) begin
      if (rst) begin
         toggle_ff <= 1'b0;
      end else if (ovf && mode_ff.toggle_output_select && !mode_ff.pulse_output_enable) begin
         toggle_ff <= !toggle_ff;
      end
   end

   // Shared pin selection
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_ff <= '0;
      end else if (mode_ff.pulse_output_enable) begin
         pin_ff <= '{o: pwm_ff, oe: 1'b1};
      end else if (mode_ff.toggle_output_select) begin
         pin_ff <= '{o: toggle_ff, oe: 1'b1};
      end else begin
         pin_ff <= gpio_drive;
      end
   end

   assign pulse_out_pin = pin_ff;

   // ****************************************************************
   // Overflow flag and interrupt request
   // ****************************************************************
   // Set beats a clear written in the same cycle
   assign nxt_flag = ovf ||
                     (flag_ff && !(wr_stat && !reg_wdata[`TPW_STAT_FLAG_BIT]));
   assign nxt_ien  = wr_stat ? reg_wdata[`TPW_STAT_IEN_BIT] : ien_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         flag_ff <= 1'b0;
         ien_ff  <= 1'b0;
         irq_ff  <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
         ien_ff  <= nxt_ien;
         irq_ff  <= nxt_flag && nxt_ien;
      end
   end

   assign overflow_irq = irq_ff;

   // ****************************************************************
   // Read port
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `TPW_ADDR_MODE:  rdata_ff <= mode_ff;
            `TPW_ADDR_COUNT: rdata_ff <= count_ff;
            `TPW_ADDR_STAT:  rdata_ff <= {6'h00, ien_ff, flag_ff};
            default:         rdata_ff <= 8'h00; // Duty is write-only
         endcase
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   assign reg_rdata = rdata_ff;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_period_high_start: assert property (
      (ovf && mode_ff.pulse_output_enable && !wr_count && !wr_mode && !wr_duty &&
       (duty_buf_ff & top) != 8'h00) |=> pwm_ff)
      else $error("pwm not high after overflow");

   a_duty_low_end: assert property (
      (mode_ff.pulse_output_enable && ((count_ff & top) == (duty_act_ff & top))) |-> !pwm_ff)
      else $error("pwm high at duty match");

   a_duty_held_buf: assert property (
      (mode_ff.timer_on && !ovf) |=> duty_act_ff == $past(duty_act_ff))
      else $error("active duty changed mid period");

   a_duty_load_ovf: assert property (
      ovf |=> duty_act_ff == $past(duty_buf_ff))
      else $error("duty not loaded at overflow");

   a_flag_on_ovf: assert property (
      ovf |=> flag_ff ##1 (flag_ff || $past(wr_stat)))
      else $error("overflow flag lost");

   a_irq_gate: assert property (
      (flag_ff && ien_ff) |-> overflow_irq)
      else $error("interrupt request missing");

   a_start_zero: assert property (
      ($rose(mode_ff.timer_on) && mode_ff.pulse_output_enable && !$past(wr_count)) |->
      count_ff == 8'h00)
      else $error("count not zero at start");

   a_wrap_zero: assert property (
      (ovf && mode_ff.pulse_output_enable && !wr_count && !wr_mode) |=> count_ff == 8'h00)
      else $error("count not wrapped to zero");

   a_pin_pwm: assert property (
      mode_ff.pulse_output_enable |=> pulse_out_pin.oe && pulse_out_pin.o == $past(pwm_ff))
      else $error("pin not driven by pwm");

   a_pin_gpio: assert property (
      (!mode_ff.pulse_output_enable && !mode_ff.toggle_output_select) |=>
      pulse_out_pin == $past(gpio_drive))
      else $error("pin not returned to gpio");

   a_toggle_ovf: assert property (
      (ovf && mode_ff.toggle_output_select && !mode_ff.pulse_output_enable) |=>
      toggle_ff != $past(toggle_ff))
      else $error("toggle did not invert");

   a_event_step: assert property (
      (mode_ff.timer_on && mode_ff.clock_source_select && ev_fall && !ovf &&
       !wr_count && !start_pwm) |=> count_ff == $past(count_ff) + 8'h01)
      else $error("event edge not counted");

   a_prescale_two: assert property (
      (mode_ff.timer_on && mode_ff.prescale_select == 3'h7 && pre_tick && !wr_mode) |=>
      !pre_tick)
      else $error("divide by two ticks too fast");

   a_ovf_top: assert property (
      ovf |-> (count_ff & top) == top && cnt_tick)
      else $error("overflow off boundary");

   c_pwm_period: cover property (ovf && mode_ff.pulse_output_enable ##[1:300] !pwm_ff);
   c_res_16: cover property (ovf && mode_ff.pulse_output_enable && top == `TPW_TOP_16);
   c_event_ovf: cover property (ovf && mode_ff.clock_source_select);
   c_set_clear: cover property (ovf && wr_stat && !reg_wdata[`TPW_STAT_FLAG_BIT]);

endmodule : tpw_timer

/* File: tpw_load.sv */
// External load on the shared output pin; measures pulse widths.
// Assumes the pin struct of tpw_pkg and a pull-up on the board net.
`timescale 1ns/10ps
module tpw_load (
   input  wire logic              clk,
   input  wire tpw_pkg::tpw_pin_s pin,
   output logic                   level,
   output logic [15:0]            high_len,
   output logic [15:0]            period_len,
   output logic [15:0]            rises
);
   logic        prev_ff;
   logic [15:0] cnt_ff;

   // ****************************************************************
   // Net level and edge-to-edge cycle counts
   // ****************************************************************
   // Undriven pin floats up through the pull-up
   assign level = pin.oe ? pin.o : 1'b1;

   // Start idle high so the pulled-up net is no rise
   initial begin
      prev_ff    <= 1'b1;
      cnt_ff     <= 16'h0000;
      high_len   <= 16'h0000;
      period_len <= 16'h0000;
      rises      <= 16'h0000;
   end

   // Count samples since the last rise
   always @(posedge clk) begin
      prev_ff <= level;
      if (level && !prev_ff) begin
         period_len <= cnt_ff;
         rises      <= rises + 16'h0001;
         cnt_ff     <= 16'h0001;
      end else begin
         cnt_ff <= cnt_ff + 16'h0001;
         if (!level && prev_ff) begin
            high_len <= cnt_ff;
         end
      end
   end
endmodule : tpw_load

/* File: tb_tpw_timer.sv */
// Self-checking bench for the timer-based pulse width modulator.
// Assumes tpw_pkg, tpw_timer and tpw_load are compiled first.
`timescale 1ns/10ps
`include "tpw_cfg.svh"
module tb_tpw_timer;
   logic              clk;
   logic              rst;
   logic [7:0]        reg_addr;
   logic [7:0]        reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [7:0]        reg_rdata;
   logic              event_input_pin;
   tpw_pkg::tpw_pin_s gpio_drive;
   tpw_pkg::tpw_pin_s pulse_out_pin;
   logic              overflow_irq;
   logic              level;
   logic [15:0]       high_len;
   logic [15:0]       period_len;
   logic [15:0]       rises;
   logic [7:0]        rd_val;
   logic [7:0]        cnt_a;
   int                bad_count;
   int                tests_run;
   int                steps [4] = '{256, 64, 32, 16};

   tpw_timer u_tpw_timer (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .event_input_pin(event_input_pin),
      .gpio_drive(gpio_drive), .pulse_out_pin(pulse_out_pin),
      .overflow_irq(overflow_irq));

   tpw_load u_tpw_load (.clk(clk), .pin(pulse_out_pin), .level(level),
      .high_len(high_len), .period_len(period_len), .rises(rises));

   // ****************************************************************
   // Clock, bus tasks and checks
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      rd_val = reg_rdata;
   endtask : rd

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t ns: saw %0h, expected %0h", $time, seen, exp);
      end
   endtask : check

   // Bounded wait for pin rises seen by the load
   task automatic wait_rises(input int n);
      logic [15:0] goal;
      int          i;
      goal = rises + 16'(n);
      i = 0;
      while (rises !== goal && i < 2000) begin
         @(posedge clk);
         #1;
         i++;
      end
      if (i == 2000) begin
         bad_count++;
         $display("[FAIL] %0t ns: no pin rise", $time);
      end
   endtask : wait_rises

   // Start-up order: clear, rate, resolution, duty, count, on, enable
   task automatic pwm_start(input logic [1:0] res, input logic [7:0] duty);
      tpw_pkg::tpw_mode_s m;
      m = '0;
      wr(`TPW_ADDR_MODE, m);
      m.prescale_select = 3'h7;
      {m.reload_select, m.toggle_output_select} = res;
      wr(`TPW_ADDR_MODE, m);
      wr(`TPW_ADDR_DUTY, duty);
      wr(`TPW_ADDR_COUNT, 8'h00);
      m.timer_on = 1'b1;
      wr(`TPW_ADDR_MODE, m);
      m.pulse_output_enable = 1'b1;
      wr(`TPW_ADDR_MODE, m);
   endtask : pwm_start

   task automatic give_verdict;
      $display("Counts: %0d checks, %0d mismatches", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict

   // Watchdog well past the expected run length
   initial begin
      repeat (30000) @(posedge clk);
      bad_count++;
      $display("[FAIL] %0t ns: watchdog expired", $time);
      give_verdict();
   end

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      rst             = 1'b1;
      reg_addr        = 8'h00;
      reg_wdata       = 8'h00;
      reg_wr          = 1'b0;
      reg_rd          = 1'b0;
      event_input_pin = 1'b1;
      gpio_drive      = '0;
      bad_count       = 0;
      tests_run       = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // Reset values, write-only duty and an unmapped place read zero
      foreach (steps[i]) begin
         rd(i == 0 ? `TPW_ADDR_COUNT : i == 1 ? `TPW_ADDR_DUTY :
            i == 2 ? `TPW_ADDR_MODE : 8'h00);
         check(16'(rd_val), 16'h0000);
      end
      $display("Test reset values finished");
      // Period and high time for every resolution code
      for (int r = 0; r < 4; r++) begin
         pwm_start(r[1:0], 8'(steps[r] / 4 + 1));
         wait_rises(3);
         check(period_len, 16'(2 * steps[r]));
         check(high_len, 16'(2 * (steps[r] / 4 + 1)));
         check(16'(pulse_out_pin.oe), 16'h0001);
      end
      $display("Test resolutions finished");
      // New duty lands only after the running period
      wait_rises(1);
      wr(`TPW_ADDR_DUTY, 8'h0C);
      wait_rises(1);
      check(high_len, 16'h000A);
      wait_rises(1);
      check(high_len, 16'h0018);
      $display("Test duty buffer finished");
      // Overflow flag and interrupt request during modulation
      wr(`TPW_ADDR_STAT, 8'h02);
      repeat (40) @(posedge clk);
      #1;
      check(16'(overflow_irq), 16'h0001);
      rd(`TPW_ADDR_STAT);
      check(16'(rd_val), 16'h0003);
      wr(`TPW_ADDR_STAT, 8'h00);
      @(posedge clk);
      #1;
      check(16'(overflow_irq), 16'h0000);
      $display("Test overflow flag finished");
      // Pin returns to GPIO while the timer keeps running
      gpio_drive <= '{o: 1'b1, oe: 1'b1};
      wr(`TPW_ADDR_MODE, 8'hF0);
      repeat (2) @(posedge clk);
      #1;
      check(16'(pulse_out_pin), 16'(gpio_drive));
      gpio_drive <= '{o: 1'b0, oe: 1'b0};
      rd(`TPW_ADDR_COUNT);
      cnt_a = rd_val;
      rd(`TPW_ADDR_COUNT);
      check(16'(pulse_out_pin), 16'(gpio_drive));
      cnt_a = rd_val - cnt_a;
      check(16'(cnt_a), 16'h0001);
      wr(`TPW_ADDR_MODE, 8'hF1);
      repeat (2) @(posedge clk);
      #1;
      check(16'(pulse_out_pin.oe), 16'h0001);
      $display("Test pin sharing finished");
      // Toggle output with matching count and reload
      wr(`TPW_ADDR_MODE, 8'h00);
      wr(`TPW_ADDR_DUTY, 8'hF0);
      wr(`TPW_ADDR_COUNT, 8'hF0);
      wr(`TPW_ADDR_MODE, 8'hF4);
      wr(`TPW_ADDR_MODE, 8'hF6);
      wait_rises(3);
      check(high_len, 16'h0020);
      check(period_len, 16'h0040);
      $display("Test toggle output finished");
      // Event source: five falling edges
      wr(`TPW_ADDR_MODE, 8'h00);
      wr(`TPW_ADDR_COUNT, 8'h00);
      wr(`TPW_ADDR_MODE, 8'h88);
      repeat (5) begin
         repeat (6) @(posedge clk);
         event_input_pin <= 1'b0;
         repeat (6) @(posedge clk);
         event_input_pin <= 1'b1;
      end
      repeat (8) @(posedge clk);
      rd(`TPW_ADDR_COUNT);
      check(16'(rd_val), 16'h0005);
      $display("Test event counter finished");
      // Every prescale code: four ticks across four divisor spans
      wr(`TPW_ADDR_MODE, 8'h00);
      for (int c = 0; c < 8; c++) begin
         wr(`TPW_ADDR_MODE, {1'b1, 3'(c), 4'h0});
         repeat (256 >> c) @(posedge clk);
         rd(`TPW_ADDR_COUNT);
         cnt_a = rd_val;
         repeat ((1024 >> c) - 2) @(posedge clk);
         rd(`TPW_ADDR_COUNT);
         cnt_a = rd_val - cnt_a;
         check(16'(cnt_a), 16'h0004);
      end
      $display("Test prescale finished");
      // Switching on with the output enabled clears a stale count
      wr(`TPW_ADDR_MODE, 8'h00);
      wr(`TPW_ADDR_COUNT, 8'h5A);
      wr(`TPW_ADDR_MODE, 8'h81);
      rd(`TPW_ADDR_COUNT);
      check(16'(rd_val), 16'h0000);
      check(16'(pulse_out_pin), 16'h0003);
      $display("Test start clear finished");
      give_verdict();
   end
endmodule : tb_tpw_timer
